// file: common/fxf_consts.vh
`ifndef FXF_CONSTS_VH
`define FXF_CONSTS_VH
// Operation classes presented on op_class_i (one-hot)
`define FXF_OPW          12
`define FXF_OP_NONE      12'h001
`define FXF_OP_FMUL      12'h002
`define FXF_OP_XMUL      12'h004
`define FXF_OP_FADDSUB   12'h008
`define FXF_OP_XADDSUB   12'h010
`define FXF_OP_DIV       12'h020
`define FXF_OP_SQRT      12'h040
`define FXF_OP_CMP       12'h080
`define FXF_OP_CVT_INT   12'h100
`define FXF_OP_WRAP      12'h200
`define FXF_OP_UNWRAP    12'h400
`define FXF_OP_LOGIC     12'h800
// Operand classes (one-hot)
`define FXF_CLW          6
`define FXF_CL_ZERO      6'h01
`define FXF_CL_DENORMAL_VALUE      6'h02
`define FXF_CL_NORM      6'h04
`define FXF_CL_INF       6'h08
`define FXF_CL_NAN       6'h10
`define FXF_CL_NONE      6'h20
// Field positions in the flag vector
`define FXF_F_OVF        0
`define FXF_F_UNF        1
`define FXF_F_INX        2
`define FXF_F_INV        3
`define FXF_FLAGS_RST    4'h0
`define FXF_NAN_ALL1     32'h7FFFFFFF
`define FXF_INF_MAG      32'h7F800000
`endif

// file: rtl/fxf_exception_flags.v
// Function
// - Normal over zero: overflow, invalid, signed infinity
// - Flags register with result, hold one cycle
// - Denormal multiplier operand: flag next cycle
// - Denormal flag both modes; not zero/inf/nan
// - Standard divide denormal: underflow, invalid, inexact tells
// - Flush divide denormal: invalid only, all-ones NaN
// - Invalid result is all-ones NaN except passes and divide by zero
// - Invalid: NaN, inf times zero, inf minus inf, convert
// - Invalid: 0/0, inf/inf, flush inf*denormal, negative root
// - Wrap nonzero normal invalid; wrap zero underflow
// - Overflow when rounded result exceeds largest normal
// - Compare: A greater overflow, A less underflow
// - Overflow on fixed add overflow or exponent subtract
// - Multiplier overflow low in fixed-point mode
// - Underflow judged after rounding, except conversion, downshift
// - Multiplier underflow tiny nonzero product, both modes
// - Flush ALU underflow tiny nonzero result, zero out
// - Standard ALU underflow only inexact denormal
// - Standard divide: tiny quotient underflows, wrapped
// - Underflow: int conversion below one, lossy unwrap
// - Underflow: exponent too negative, shift all out
// - Fixed multiply inexact when low product half nonzero
`timescale 1ns/100ps
`include "fxf_consts.vh"
module fxf_exception_flags
(
  input  wire                  clk_i,
  input  wire                  reset_i,
  input  wire                  flush_mode_i,       // High selects flush mode, low standard mode
  input  wire [`FXF_OPW-1:0]   op_class_i,         // One-hot operation now finishing
  input  wire                  result_load_i,      // Result enters output register this edge
  input  wire [31:0]           operand_a_i,
  input  wire [31:0]           operand_b_i,
  input  wire                  operand_read_controls_i, // Operand pair read into multiplier array
  input  wire                  round_overflow_i,   // Datapath: rounded unbounded result above largest normal
  input  wire                  round_tiny_i,       // Datapath: rounded nonzero result below smallest normal
  input  wire                  round_inexact_i,    // Datapath: rounding lost accuracy
  input  wire                  result_denormal_i,  // Datapath: rounded result is a denormal
  input  wire                  fix_overflow_i,     // Fixed add/sub twos-complement overflow
  input  wire                  exp_sub_high_i,     // Exponent subtract too positive
  input  wire                  exp_sub_low_i,      // Exponent subtract too negative
  input  wire                  shift_all_out_i,    // Logical downshift loses every bit
  input  wire                  pre_round_below_one_i, // Float-to-int source magnitude below one
  input  wire                  unwrap_lossy_i,     // Unwrap lost accuracy
  input  wire                  subtract_i,         // Effective subtract on add/sub path
  input  wire                  sign_copy_i,        // Sign copy onto NaN, not an invalid case
  input  wire                  logic_pass_i,       // Logical pass of a NaN
  input  wire [63:0]           fix_product_i,      // Full pre-rounded fixed-point product
  input  wire [31:0]           datapath_result_i,  // Normal datapath result
  output reg                   overflow_flag_o,
  output reg                   underflow_flag_o,
  output reg                   inexact_flag_o,
  output reg                   invalid_op_flag_o,
  output reg                   denormal_input_flag_o,
  output reg  [31:0]           result_o
);
  wire [`FXF_CLW-1:0] cls_a;
  wire [`FXF_CLW-1:0] cls_b;
  wire                sgn_a;
  wire                sgn_b;

  // One classifier per operand
  fxf_operand_class u_cls_a
  (
    .value_i   (operand_a_i),
    .present_i (1'b1),
    .class_o   (cls_a),
    .sign_o    (sgn_a)
  );

  fxf_operand_class u_cls_b
  (
    .value_i   (operand_b_i),
    .present_i (1'b1),
    .class_o   (cls_b),
    .sign_o    (sgn_b)
  );

  wire a_zero = (cls_a == `FXF_CL_ZERO);
  wire b_zero = (cls_b == `FXF_CL_ZERO);
  wire a_dn   = (cls_a == `FXF_CL_DENORMAL_VALUE);
  wire b_dn   = (cls_b == `FXF_CL_DENORMAL_VALUE);
  wire a_inf  = (cls_a == `FXF_CL_INF);
  wire b_inf  = (cls_b == `FXF_CL_INF);
  wire a_nan  = (cls_a == `FXF_CL_NAN);
  wire b_nan  = (cls_b == `FXF_CL_NAN);
  wire a_fin  = ~a_inf & ~a_nan;
  wire any_nan = a_nan | b_nan;

  wire op_fmul = (op_class_i == `FXF_OP_FMUL);
  wire op_xmul = (op_class_i == `FXF_OP_XMUL);
  wire op_fadd = (op_class_i == `FXF_OP_FADDSUB);
  wire op_xadd = (op_class_i == `FXF_OP_XADDSUB);
  wire op_div  = (op_class_i == `FXF_OP_DIV);
  wire op_sqrt = (op_class_i == `FXF_OP_SQRT);
  wire op_cmp  = (op_class_i == `FXF_OP_CMP);
  wire op_cvt  = (op_class_i == `FXF_OP_CVT_INT);
  wire op_wrap = (op_class_i == `FXF_OP_WRAP);
  wire op_unwr = (op_class_i == `FXF_OP_UNWRAP);
  wire op_log  = (op_class_i == `FXF_OP_LOGIC);

  // Comparison ordering on magnitude with sign; zeros compare equal regardless of sign
  wire a_is_z     = a_zero;
  wire b_is_z     = b_zero;
  wire both_z     = a_is_z & b_is_z;
  wire a_mag_gt   = (operand_a_i[30:0] > operand_b_i[30:0]);
  wire a_mag_lt   = (operand_a_i[30:0] < operand_b_i[30:0]);
  reg  cmp_gt;
  reg  cmp_lt;

  // Signed ordering of two non-NaN operands
  always @*
  begin
    cmp_gt = 1'b0;
    cmp_lt = 1'b0;
    if (!both_z)
    begin
      if (sgn_a != sgn_b)
      begin
        cmp_gt = ~sgn_a | (b_is_z & ~a_is_z & 1'b0);
        cmp_lt = sgn_a;
        if (a_is_z)
        begin
          cmp_gt = sgn_b;
          cmp_lt = ~sgn_b;
        end
        else if (b_is_z)
        begin
          cmp_gt = ~sgn_a;
          cmp_lt = sgn_a;
        end
      end
      else
      begin
        cmp_gt = sgn_a ? a_mag_lt : a_mag_gt;
        cmp_lt = sgn_a ? a_mag_gt : a_mag_lt;
      end
    end
  end

  // Denormal operands reaching divide or root
  wire dn_in     = a_dn | b_dn;
  wire dn_divsqr = (op_div & dn_in) | (op_sqrt & a_dn);
  wire div_by_0  = op_div & b_zero & a_fin & ~a_zero & ~a_dn & ~b_nan;

  // Invalid sources, combined per operation
  wire inv_nan   = any_nan & ~op_log & ~logic_pass_i & ~sign_copy_i;
  wire inv_mul   = op_fmul & ((a_inf & b_zero) | (b_inf & a_zero) |
                              (flush_mode_i & ((a_inf & b_dn) | (b_inf & a_dn))));
  wire inv_add   = op_fadd & a_inf & b_inf & ((sgn_a == sgn_b) == subtract_i);
  wire inv_cvt   = op_cvt & (a_inf | a_nan);
  wire inv_div   = op_div & ((a_zero & b_zero) | (a_inf & b_inf));
  wire inv_sqrt  = op_sqrt & sgn_a & ~a_zero & ~a_nan;
  wire inv_wrap  = op_wrap & ~a_dn & ~a_zero;
  wire inv_any   = inv_nan | inv_mul | inv_add | inv_cvt | inv_div | inv_sqrt |
                   inv_wrap | div_by_0 | dn_divsqr;

  // Next-flag decode
  reg       ovf_d;
  reg       unf_d;
  reg       inx_d;
  reg [31:0] res_d;

  // Each flag is built per operation, then special results override the datapath value
  always @*
  begin
    ovf_d = 1'b0;
    unf_d = 1'b0;
    inx_d = 1'b0;
    res_d = datapath_result_i;
    if (op_cmp)
    begin
      if (!any_nan)
      begin
        ovf_d = cmp_gt;
        unf_d = cmp_lt;
      end
    end
    else if (op_xmul)
    begin
      ovf_d = 1'b0;
      inx_d = (fix_product_i[31:0] != 32'h00000000);
    end
    else if (op_xadd)
      ovf_d = fix_overflow_i;
    else if (op_log)
      unf_d = shift_all_out_i;
    else if (op_wrap)
      unf_d = a_zero;
    else if (op_unwr)
      unf_d = unwrap_lossy_i;
    else if (op_cvt)
    begin
      ovf_d = round_overflow_i;
      unf_d = pre_round_below_one_i;
      inx_d = round_inexact_i;
    end
    else if (dn_divsqr)
    begin
      unf_d = ~flush_mode_i;
      inx_d = ~flush_mode_i & op_div & a_dn & ~b_dn;
    end
    else if (div_by_0)
      ovf_d = 1'b1;
    else if (!inv_any)
    begin
      ovf_d = round_overflow_i | exp_sub_high_i;
      inx_d = round_inexact_i;
      if (op_fmul)
        unf_d = round_tiny_i;
      else if (flush_mode_i)
        unf_d = round_tiny_i;
      else if (op_div)
        unf_d = round_tiny_i;
      else
        unf_d = result_denormal_i & round_inexact_i;
      unf_d = unf_d | exp_sub_low_i;
      // Flush mode has no denormal form, so a tiny result leaves as a signed zero
      if (flush_mode_i && round_tiny_i)
        res_d = {datapath_result_i[31], 31'h00000000};
    end
    // Special results
    if (div_by_0)
      res_d = {sgn_a ^ sgn_b, 31'h00000000} | `FXF_INF_MAG;
    else if (inv_any && !(a_nan && (op_log || logic_pass_i || sign_copy_i)))
      res_d = {sgn_a ^ sgn_b, 31'h00000000} | `FXF_NAN_ALL1;
  end

  // Early denormal flag for multiplier reads; zero, infinity and NaN partners need no wrap
  wire dn_mul_d = operand_read_controls_i & (a_dn | b_dn) &
                  ~(a_zero | b_zero | a_inf | b_inf | a_nan | b_nan);

  // Denormal flag goes high the cycle after the read, independent of mode
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      denormal_input_flag_o <= 1'b0;
    else
      denormal_input_flag_o <= dn_mul_d;
  end

  // Status output register loads with the result; flags last one cycle, sticky latching is outside
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      overflow_flag_o   <= 1'b0;
      underflow_flag_o  <= 1'b0;
      inexact_flag_o    <= 1'b0;
      invalid_op_flag_o <= 1'b0;
      result_o          <= 32'h00000000;
    end
    else if (result_load_i)
    begin
      overflow_flag_o   <= ovf_d;
      underflow_flag_o  <= unf_d;
      inexact_flag_o    <= inx_d;
      invalid_op_flag_o <= inv_any;
      result_o          <= res_d;
    end
    else
    begin
      overflow_flag_o   <= 1'b0;
      underflow_flag_o  <= 1'b0;
      inexact_flag_o    <= 1'b0;
      invalid_op_flag_o <= 1'b0;
    end
  end
endmodule // fxf_exception_flags

// file: rtl/fxf_operand_class.v
`timescale 1ns/100ps
`include "fxf_consts.vh"
// Classifies one single-precision operand
module fxf_operand_class
(
  input  wire [31:0]           value_i,
  input  wire                  present_i,
  output reg  [`FXF_CLW-1:0]   class_o,
  output wire                  sign_o
);
  wire [7:0]  exp_w  = value_i[30:23];
  wire [22:0] frac_w = value_i[22:0];

  assign sign_o = value_i[31];

  // Exponent extremes decide the class; absent operands stay out of every test
  always @*
  begin
    if (!present_i)
      class_o = `FXF_CL_NONE;
    else if (exp_w == 8'hFF)
      class_o = (frac_w == 23'h000000) ? `FXF_CL_INF : `FXF_CL_NAN;
    else if (exp_w == 8'h00)
      class_o = (frac_w == 23'h000000) ? `FXF_CL_ZERO : `FXF_CL_DENORMAL_VALUE;
    else
      class_o = `FXF_CL_NORM;
  end
endmodule // fxf_operand_class

// file: tb/fxf_exception_flags_sva.sv
`timescale 1ns/100ps
`include "fxf_consts.vh"
// Ties every registered flag to the operands and op class of the load edge, the denormal flag to the multiplier read edge
module fxf_flags_sva
(
  input wire                clk_i,
  input wire                reset_i,
  input wire                flush_mode_i,
  input wire [`FXF_OPW-1:0] op_class_i,
  input wire                result_load_i,
  input wire [31:0]         operand_a_i,
  input wire [31:0]         operand_b_i,
  input wire                operand_read_controls_i,
  input wire [63:0]         fix_product_i,
  input wire                overflow_flag_o,
  input wire                underflow_flag_o,
  input wire                inexact_flag_o,
  input wire                invalid_op_flag_o,
  input wire                denormal_input_flag_o,
  input wire [31:0]         result_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Operand classes, sign ignored
  wire       a_dn = operand_a_i[30:23] == 8'h00 && operand_a_i[22:0] != 23'h0;
  wire       b_dn = operand_b_i[30:23] == 8'h00 && operand_b_i[22:0] != 23'h0;
  wire       a_nm = operand_a_i[30:23] != 8'h00 && operand_a_i[30:23] != 8'hFF;
  wire       b_nm = operand_b_i[30:23] != 8'h00 && operand_b_i[30:23] != 8'hFF;
  wire       b_z  = operand_b_i[30:0] == 31'h0;
  wire       ld   = result_load_i;
  wire       rd   = operand_read_controls_i && op_class_i == `FXF_OP_FMUL;
  wire [3:0] fl   = {invalid_op_flag_o, inexact_flag_o, underflow_flag_o, overflow_flag_o};
  property p_idle_clear; !ld |=> fl == 4'h0; endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("flags set without a load");
  property p_div_zero; ld && op_class_i == `FXF_OP_DIV && a_nm && b_z |=> fl[0] && fl[3] && result_o[30:0] == 31'h7F800000; endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero flags or result wrong");
  property p_cmp_gt; ld && op_class_i == `FXF_OP_CMP && !operand_a_i[31] && !operand_b_i[31] && a_nm && b_nm
    && operand_a_i[30:0] > operand_b_i[30:0] |=> fl[1:0] == 2'b01; endproperty
  a_cmp_gt: assert property (p_cmp_gt) else $error("greater compare flags wrong");
  property p_xmul; ld && op_class_i == `FXF_OP_XMUL |=> !overflow_flag_o && inexact_flag_o == |$past(fix_product_i[31:0]); endproperty
  a_xmul: assert property (p_xmul) else $error("fixed multiply overflow or inexact wrong");
  property p_inf_zero; ld && op_class_i == `FXF_OP_FMUL && operand_a_i[30:0] == 31'h7F800000 && b_z
    |=> invalid_op_flag_o && result_o[30:0] == 31'h7FFFFFFF; endproperty
  a_inf_zero: assert property (p_inf_zero) else $error("infinity times zero not invalid");
  property p_wrap_zero; ld && op_class_i == `FXF_OP_WRAP && operand_a_i[30:0] == 31'h0 |=> underflow_flag_o; endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap of zero not underflow");
  property p_dn_flag; rd && (a_dn && b_nm || b_dn && a_nm) |=> denormal_input_flag_o; endproperty
  a_dn_flag: assert property (p_dn_flag) else $error("denormal input flag missing");
  property p_dn_zero; rd && a_dn && b_z |=> !denormal_input_flag_o; endproperty
  a_dn_zero: assert property (p_dn_zero) else $error("denormal flag raised for zero product");
  property p_div_dn; ld && op_class_i == `FXF_OP_DIV && a_dn && b_nm |=> fl == ($past(flush_mode_i) ? 4'h8 : 4'hE); endproperty
  a_div_dn: assert property (p_div_dn) else $error("denormal dividend flags wrong");
  c_div_zero: cover property (ld && op_class_i == `FXF_OP_DIV && b_z);
  c_cmp: cover property (ld && op_class_i == `FXF_OP_CMP);
  c_dn: cover property (rd && a_dn);
endmodule // fxf_flags_sva
bind fxf_exception_flags fxf_flags_sva fxf_flags_sva_inst (.clk_i(clk_i), .reset_i(reset_i),
  .flush_mode_i(flush_mode_i), .op_class_i(op_class_i), .result_load_i(result_load_i), .operand_a_i(operand_a_i),
  .operand_b_i(operand_b_i), .operand_read_controls_i(operand_read_controls_i), .fix_product_i(fix_product_i),
  .overflow_flag_o(overflow_flag_o), .underflow_flag_o(underflow_flag_o), .inexact_flag_o(inexact_flag_o),
  .invalid_op_flag_o(invalid_op_flag_o), .denormal_input_flag_o(denormal_input_flag_o), .result_o(result_o));

// file: tb/fxf_exception_flags_tb.sv
`timescale 1ns/100ps
`include "fxf_consts.vh"
module fxf_exception_flags_tb;
  localparam [31:0] ONE = 32'h3F800000, TWO = 32'h40000000, INF = 32'h7F800000, DN = 32'h00000001;
  localparam [31:0] QN = 32'h7FC00000, Z = 32'h00000000;
  reg                clk_i = 1'b0;
  reg                reset_i = 1'b1;
  reg                flush_mode_i = 1'b0;
  reg [`FXF_OPW-1:0] op_class_i = `FXF_OP_NONE;
  reg                result_load_i = 1'b0;
  reg [31:0]         operand_a_i = 32'h0;
  reg [31:0]         operand_b_i = 32'h0;
  reg                read_q = 1'b0;
  reg [11:0]         st_q = 12'h000;
  reg [63:0]         fix_product_i = 64'h0;
  reg                clear_q = 1'b0;
  reg                copy_q = 1'b0;
  wire               ovf, unf, inx, inv, denormal_value;
  wire [31:0]        result_o;
  wire [3:0]         sticky;
  integer            n_errors = 0;
  integer            tests_run = 0;
  // Half period of 2 ns gives the 250 MHz clock
  always #2 clk_i = ~clk_i;
  fxf_exception_flags fxf_exception_flags_inst (.clk_i(clk_i), .reset_i(reset_i), .flush_mode_i(flush_mode_i),
    .op_class_i(op_class_i), .result_load_i(result_load_i), .operand_a_i(operand_a_i), .operand_b_i(operand_b_i),
    .operand_read_controls_i(read_q), .round_overflow_i(st_q[11]), .round_tiny_i(st_q[10]),
    .round_inexact_i(st_q[9]), .result_denormal_i(st_q[8]), .fix_overflow_i(st_q[7]), .exp_sub_high_i(st_q[6]),
    .exp_sub_low_i(st_q[5]), .shift_all_out_i(st_q[4]), .pre_round_below_one_i(st_q[3]), .unwrap_lossy_i(st_q[2]),
    .subtract_i(st_q[1]), .sign_copy_i(copy_q), .logic_pass_i(st_q[0]), .fix_product_i(fix_product_i),
    .datapath_result_i(operand_a_i), .overflow_flag_o(ovf), .underflow_flag_o(unf), .inexact_flag_o(inx),
    .invalid_op_flag_o(inv), .denormal_input_flag_o(denormal_value), .result_o(result_o));
  fxf_flag_latch fxf_flag_latch_inst (.clk_i(clk_i), .reset_i(reset_i), .clear_i(clear_q),
    .flags_i({inv, inx, unf, ovf}), .sticky_o(sticky));
  task chk(input string what, input [31:0] exp, input [31:0] got);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // One load cycle from a falling edge; loads may follow back to back
  task run(input [11:0] op, input fm, input [31:0] a, input [31:0] b, input [11:0] st, input [3:0] ef);
  begin
    op_class_i = op;
    flush_mode_i = fm;
    operand_a_i = a;
    operand_b_i = b;
    st_q = st;
    read_q = 1'b0;
    result_load_i = 1'b1;
    @(negedge clk_i);
    chk("flags", {28'h0, ef}, {28'h0, inv, inx, unf, ovf});
    $display("test op %h done", op);
  end
  endtask
  // Multiplier operand read with no load; flags must stay low meanwhile
  task dn(input [31:0] a, input [31:0] b, input fm, input e);
  begin
    op_class_i = `FXF_OP_FMUL;
    flush_mode_i = fm;
    operand_a_i = a;
    operand_b_i = b;
    read_q = 1'b1;
    result_load_i = 1'b0;
    @(negedge clk_i);
    chk("idle flags", 32'h0, {28'h0, inv, inx, unf, ovf});
    chk("denormal", {31'h0, e}, {31'h0, denormal_value});
    $display("test denormal read done");
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Main sequence; every answer is due one edge after the load
  initial
  begin
    repeat (20) @(negedge clk_i);
    chk("reset outputs", 32'h0, {inv, inx, unf, ovf, denormal_value, result_o[26:0]});
    reset_i = 1'b0;
    @(negedge clk_i);
    run(`FXF_OP_DIV, 0, ONE, Z, 12'h000, 4'h9);
    chk("result", INF, result_o);
    run(`FXF_OP_DIV, 0, ONE | 32'h80000000, Z, 12'h000, 4'h9);
    chk("result", INF | 32'h80000000, result_o);
    dn(DN, ONE, 0, 1);
    chk("sticky", 32'h9, {28'h0, sticky});
    clear_q = 1'b1;
    dn(DN, ONE, 1, 1);
    clear_q = 1'b0;
    dn(DN, Z, 0, 0);
    chk("sticky", 32'h0, {28'h0, sticky});
    dn(DN, QN, 0, 0);
    run(`FXF_OP_CMP, 0, TWO, ONE, 12'h000, 4'h1);
    run(`FXF_OP_CMP, 0, ONE, TWO, 12'h000, 4'h2);
    run(`FXF_OP_CMP, 0, ONE, ONE, 12'h000, 4'h0);
    run(`FXF_OP_CMP, 0, QN, ONE, 12'h000, 4'h8);
    run(`FXF_OP_FMUL, 0, INF, 32'h80000000, 12'h000, 4'h8);
    chk("result", 32'hFFFFFFFF, result_o);
    run(`FXF_OP_FADDSUB, 0, INF, INF, 12'h002, 4'h8);
    run(`FXF_OP_CVT_INT, 0, INF, Z, 12'h000, 4'h8);
    run(`FXF_OP_CVT_INT, 0, 32'h3E800000, Z, 12'h008, 4'h2);
    run(`FXF_OP_DIV, 0, Z, Z, 12'h000, 4'h8);
    run(`FXF_OP_DIV, 0, INF, INF, 12'h000, 4'h8);
    run(`FXF_OP_FMUL, 1, INF, DN, 12'h000, 4'h8);
    run(`FXF_OP_SQRT, 0, ONE | 32'h80000000, Z, 12'h000, 4'h8);
    run(`FXF_OP_WRAP, 0, ONE, Z, 12'h000, 4'h8);
    run(`FXF_OP_WRAP, 0, Z, Z, 12'h000, 4'h2);
    run(`FXF_OP_DIV, 0, DN, ONE, 12'h000, 4'hE);
    run(`FXF_OP_DIV, 0, ONE, DN, 12'h000, 4'hA);
    run(`FXF_OP_DIV, 0, DN, DN, 12'h000, 4'hA);
    run(`FXF_OP_DIV, 1, DN, ONE, 12'h000, 4'h8);
    chk("result", `FXF_NAN_ALL1, result_o & 32'h7FFFFFFF);
    run(`FXF_OP_SQRT, 1, DN, Z, 12'h000, 4'h8);
    run(`FXF_OP_FMUL, 0, TWO, TWO, 12'h800, 4'h1);
    run(`FXF_OP_FMUL, 1, DN, ONE, 12'h400, 4'h2);
    run(`FXF_OP_FADDSUB, 1, ONE, ONE, 12'h400, 4'h2);
    chk("result", Z, result_o);
    run(`FXF_OP_FADDSUB, 0, ONE, ONE, 12'h500, 4'h0);
    run(`FXF_OP_FADDSUB, 0, ONE, ONE, 12'h700, 4'h6);
    run(`FXF_OP_FADDSUB, 0, ONE, ONE, 12'h200, 4'h4);
    run(`FXF_OP_DIV, 0, ONE, TWO, 12'h400, 4'h2);
    run(`FXF_OP_XADDSUB, 0, ONE, TWO, 12'h080, 4'h1);
    fix_product_i = 64'h0000000100000001;
    run(`FXF_OP_XMUL, 0, ONE, TWO, 12'h800, 4'h4);
    fix_product_i = 64'hFFFFFFFF00000000;
    run(`FXF_OP_XMUL, 0, ONE, TWO, 12'h000, 4'h0);
    copy_q = 1'b1;
    run(`FXF_OP_FADDSUB, 0, QN, ONE, 12'h000, 4'h0);
    chk("result", QN, result_o);
    copy_q = 1'b0;
    run(`FXF_OP_FADDSUB, 0, QN, ONE, 12'h001, 4'h0);
    chk("result", QN, result_o);
    result_load_i = 1'b0;
    @(negedge clk_i);
    chk("idle flags", 32'h0, {28'h0, inv, inx, unf, ovf});
    end_sim;
  end
endmodule // fxf_exception_flags_tb

// file: tb/fxf_flag_latch.sv
`timescale 1ns/100ps
// Sticky holder of the one-cycle device flags, cleared only on reset or on request
module fxf_flag_latch
(
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       clear_i,
  input  wire [3:0] flags_i,
  output reg  [3:0] sticky_o
);
  // Each flag is kept apart, since the device pulses last one cycle only
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i || clear_i)
      sticky_o <= 4'h0;
    else
      sticky_o <= sticky_o | flags_i;
  end
endmodule // fxf_flag_latch
